// >>> hw/mmucr_regs.sv
`timescale 1ns/10ps
module mmucr_regs
(
   input wire logic core_clk,
   input wire logic sys_rst,
   // Coprocessor register transfer from the core
   input wire logic cp_req,
   input wire logic cp_write,
   input wire logic [3:0] cp_reg,
   input wire logic [31:0] cp_wdata,
   input wire logic cp_user_mode,
   output logic cp_ack_r,
   output logic cp_undef_r,
   output logic [31:0] cp_rdata_r,
   // Fault reports from the MMU
   input wire logic flt_valid,
   input wire logic flt_prefetch,
   input wire logic [3:0] flt_domain,
   input wire logic [3:0] flt_type,
   input wire logic [31:0] flt_addr,
   // Internal data bus, same clock
   input wire logic [31:0] int_dbus,
   // Controls toward MMU and cache
   output logic [31:0] domain_access_r,
   output logic tlb_flush_all_r,
   output logic tlb_purge_r,
   output logic [31:0] tlb_purge_addr_r,
   output logic unified_cache_flush_r
);

   logic [31:0] domain_access_nxt;
   logic [3:0] fs_domain_r;
   logic [3:0] fs_domain_nxt;
   logic [3:0] fs_type_r;
   logic [3:0] fs_type_nxt;
   logic [31:0] fault_addr_r;
   logic [31:0] fault_addr_nxt;
   logic [31:0] last_bus_r;
   logic [31:0] last_bus_nxt;
   logic cp_ack_nxt;
   logic cp_undef_nxt;
   logic [31:0] cp_rdata_nxt;
   logic tlb_flush_all_nxt;
   logic tlb_purge_nxt;
   logic [31:0] tlb_purge_addr_nxt;
   logic unified_cache_flush_nxt;
   logic trap;
   logic do_rd;
   logic do_wr;

   // Decode; a trapped access performs nothing at all
   always_comb
   begin
      trap = cp_req & (cp_user_mode |
         (cp_reg >= mmucr_pkg::MMUCR_REG_FIRST_UNDEF));
      do_rd = cp_req & ~trap & ~cp_write;
      do_wr = cp_req & ~trap & cp_write;
   end

   // Fault capture and bus history
   always_comb
   begin
      fs_domain_nxt = fs_domain_r;
      fs_type_nxt = fs_type_r;
      fault_addr_nxt = fault_addr_r;
      last_bus_nxt = int_dbus; // Upper status bits mirror this bus
      // Prefetch faults must not disturb the data-fault record
      if (flt_valid && !flt_prefetch)
      begin
         fs_domain_nxt = flt_domain;
         fs_type_nxt = flt_type;
         fault_addr_nxt = flt_addr;
      end
   end

   // Domain word and transfer answer
   always_comb
   begin
      domain_access_nxt = domain_access_r;
      cp_ack_nxt = cp_req & ~trap;
      cp_undef_nxt = trap;
      cp_rdata_nxt = mmucr_pkg::MMUCR_RDATA_NONE;
      tlb_flush_all_nxt = 1'b0;
      tlb_purge_nxt = 1'b0;
      tlb_purge_addr_nxt = tlb_purge_addr_r;
      unified_cache_flush_nxt = 1'b0;
      if (do_wr)
      begin
         case (cp_reg)
            mmucr_pkg::MMUCR_REG_DOMAIN:
            begin
               domain_access_nxt = cp_wdata;
            end
            mmucr_pkg::MMUCR_REG_FSTAT:
            begin
               tlb_flush_all_nxt = 1'b1;
            end
            mmucr_pkg::MMUCR_REG_FADDR:
            begin
               // The TLB does the match; only that entry is dropped
               tlb_purge_nxt = 1'b1;
               tlb_purge_addr_nxt = cp_wdata;
            end
            mmucr_pkg::MMUCR_REG_CACHE:
            begin
               unified_cache_flush_nxt = 1'b1;
            end
            default:
            begin
               // Register 4 and unused numbers change nothing
               domain_access_nxt = domain_access_r;
            end
         endcase
      end
      if (do_rd)
      begin
         case (cp_reg)
            mmucr_pkg::MMUCR_REG_FSTAT:
            begin
               // Stale bus bits are returned as the core would see them
               cp_rdata_nxt = {last_bus_r[31:mmucr_pkg::MMUCR_FS_BUS_LSB],
                  4'h0, fs_domain_r, fs_type_r};
            end
            mmucr_pkg::MMUCR_REG_FADDR:
            begin
               cp_rdata_nxt = fault_addr_r;
            end
            default:
            begin
               // Domain word and cache register are write-only
               cp_rdata_nxt = mmucr_pkg::MMUCR_RDATA_NONE;
            end
         endcase
      end
   end

   // State registers
   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         domain_access_r <= mmucr_pkg::MMUCR_DOMAIN_RST;
         fs_domain_r <= mmucr_pkg::MMUCR_FS_FIELD_RST;
         fs_type_r <= mmucr_pkg::MMUCR_FS_FIELD_RST;
         fault_addr_r <= mmucr_pkg::MMUCR_FADDR_RST;
         last_bus_r <= mmucr_pkg::MMUCR_RDATA_NONE;
         cp_ack_r <= 1'b0;
         cp_undef_r <= 1'b0;
         cp_rdata_r <= mmucr_pkg::MMUCR_RDATA_NONE;
         tlb_flush_all_r <= 1'b0;
         tlb_purge_r <= 1'b0;
         tlb_purge_addr_r <= mmucr_pkg::MMUCR_FADDR_RST;
         unified_cache_flush_r <= 1'b0;
      end
      else
      begin
         domain_access_r <= domain_access_nxt;
         fs_domain_r <= fs_domain_nxt;
         fs_type_r <= fs_type_nxt;
         fault_addr_r <= fault_addr_nxt;
         last_bus_r <= last_bus_nxt;
         cp_ack_r <= cp_ack_nxt;
         cp_undef_r <= cp_undef_nxt;
         cp_rdata_r <= cp_rdata_nxt;
         tlb_flush_all_r <= tlb_flush_all_nxt;
         tlb_purge_r <= tlb_purge_nxt;
         tlb_purge_addr_r <= tlb_purge_addr_nxt;
         unified_cache_flush_r <= unified_cache_flush_nxt;
      end
   end

endmodule

// >>> include/mmucr_pkg.sv
// Function
// - Domain access word is write-only, sixteen two-bit fields, domain 0 lowest.
// - Register 4 access changes nothing; software must never access it.
// - Reading register 5 returns status of the latest data fault.
// - Prefetch faults leave captured status untouched; only data faults update.
// - Status read: low 12 bits meaningful, upper 20 show last internal bus.
// - Status bits eleven to eight always read zero.
// - Any write to register 5 flushes the whole TLB, data ignored.
// - Reading register 6 returns virtual address of latest data fault.
// - Write to register 6 purges only the TLB entry matching the address.
// - Register 7 write-only; a write flushes the unified cache, data ignored.
// - Access to registers eight to fifteen takes the undefined trap.
// - Accesses only in privileged modes; user mode takes the undefined trap.
package mmucr_pkg;
   // Control register numbers
   localparam logic [3:0] MMUCR_REG_DOMAIN = 4'h3;
   localparam logic [3:0] MMUCR_REG_RSVD4 = 4'h4;
   localparam logic [3:0] MMUCR_REG_FSTAT = 4'h5;
   localparam logic [3:0] MMUCR_REG_FADDR = 4'h6;
   localparam logic [3:0] MMUCR_REG_CACHE = 4'h7;
   localparam logic [3:0] MMUCR_REG_FIRST_UNDEF = 4'h8;
   // Fault status field layout
   localparam int MMUCR_FS_TYPE_LSB = 0;
   localparam int MMUCR_FS_DOM_LSB = 4;
   localparam int MMUCR_FS_ZERO_LSB = 8;
   localparam int MMUCR_FS_BUS_LSB = 12;
   localparam int MMUCR_DOM_FIELD_W = 2;
   // Reset values
   localparam logic [31:0] MMUCR_DOMAIN_RST = 32'h0000_0000;
   localparam logic [3:0] MMUCR_FS_FIELD_RST = 4'h0;
   localparam logic [31:0] MMUCR_FADDR_RST = 32'h0000_0000;
   localparam logic [31:0] MMUCR_RDATA_NONE = 32'h0000_0000;
endpackage

// >>> test/mmucr_mmu_model.sv
`timescale 1ns/10ps
// Stands in for the fault reporter and the busy internal data bus
module mmucr_mmu_model (
   input wire logic core_clk,
   output logic flt_valid, flt_prefetch,
   output logic [3:0] flt_domain, flt_type,
   output logic [31:0] flt_addr, int_dbus
);
   // Quiet start
   initial
      {flt_valid, flt_prefetch, flt_domain, flt_type, flt_addr, int_dbus} = '0;
   // Bus churns every cycle so stale status bits cannot pass as a match
   always @(posedge core_clk)
      int_dbus <= #1 int_dbus + 32'h1357_9BDF;
   // One-cycle report, then an idle cycle so reports never merge
   task report(input logic p, input logic [3:0] d, t, input logic [31:0] a);
      {flt_valid, flt_prefetch, flt_domain, flt_type} = {1'b1, p, d, t};
      flt_addr = a;
      @(posedge core_clk);
      #1 flt_valid = 1'b0;
      @(posedge core_clk);
      #1;
   endtask
endmodule

// >>> test/mmucr_chk.sv
`timescale 1ns/10ps
module mmucr_chk (
   input wire logic core_clk, sys_rst, cp_req, cp_write, cp_user_mode,
   input wire logic [3:0] cp_reg,
   input wire logic cp_ack_r, cp_undef_r, tlb_flush_all_r, tlb_purge_r,
   input wire logic unified_cache_flush_r,
   input wire logic [31:0] cp_rdata_r
);
   default clocking @(posedge core_clk);
   endclocking
   default disable iff (sys_rst);
   // Privileged request to one register number
   sequence s_req(w, n);
      cp_req && cp_write == w && !cp_user_mode && cp_reg == n;
   endsequence
   a_tlb_flush: assert property (s_req(1, 5) |=> tlb_flush_all_r)
      else $error("flush lost");
   a_tlb_purge: assert property (s_req(1, 6) |=> tlb_purge_r)
      else $error("purge lost");
   a_cache_flush: assert property (s_req(1, 7) |=> unified_cache_flush_r)
      else $error("cache flush lost");
   a_flush_cause: assert property (unified_cache_flush_r |-> $past(cp_req)
      && $past(cp_write) && !$past(cp_user_mode) && $past(cp_reg) == 4'h7)
      else $error("stray");
   a_status_zero: assert property (s_req(0, 5) |=> cp_rdata_r[11:8] == 0)
      else $error("status bits set");
   // Software never touches register 4, so guard the effect side instead
   a_rsvd_quiet: assert property (tlb_flush_all_r || tlb_purge_r |->
      $past(cp_req) && $past(cp_write) && !$past(cp_user_mode)
      && ($past(cp_reg) == 4'h5 || $past(cp_reg) == 4'h6))
      else $error("rsvd");
   a_high_trap: assert property (cp_req && cp_reg[3] |=> cp_undef_r
      && !cp_ack_r) else $error("no trap");
   a_user_trap: assert property (cp_req && cp_user_mode |=> cp_undef_r
      && cp_rdata_r == 0) else $error("user not trapped");
endmodule
bind mmucr_regs mmucr_chk chk (.core_clk, .sys_rst, .cp_req, .cp_write,
   .cp_user_mode, .cp_reg, .cp_ack_r, .cp_undef_r, .tlb_flush_all_r,
   .tlb_purge_r, .unified_cache_flush_r, .cp_rdata_r);

// >>> test/tb_mmucr_regs.sv
`timescale 1ns/10ps
module tb_mmucr_regs;
   logic core_clk = 0, sys_rst = 1, cp_req = 0, cp_write = 0;
   logic cp_user_mode = 0, cp_ack_r, cp_undef_r, flt_valid, flt_prefetch;
   logic tlb_flush_all_r, tlb_purge_r, unified_cache_flush_r;
   logic [3:0] cp_reg = 0, flt_domain, flt_type;
   logic [31:0] cp_wdata = 0, cp_rdata_r, flt_addr, int_dbus, bus, q;
   logic [31:0] domain_access_r, tlb_purge_addr_r, bus_q;
   logic [4:0] flags;
   int failures = 0, comparisons = 0, cyc = 0;
   mmucr_regs uut (.core_clk, .sys_rst, .cp_req, .cp_write, .cp_reg,
      .cp_wdata, .cp_user_mode, .cp_ack_r, .cp_undef_r, .cp_rdata_r,
      .flt_valid, .flt_prefetch, .flt_domain, .flt_type, .flt_addr,
      .int_dbus, .domain_access_r, .tlb_flush_all_r, .tlb_purge_r,
      .tlb_purge_addr_r, .unified_cache_flush_r);
   mmucr_mmu_model mmu (.core_clk, .flt_valid, .flt_prefetch, .flt_domain,
      .flt_type, .flt_addr, .int_dbus);
   // 100 MHz clock
   always #5 core_clk = ~core_clk;
   // Bus as the block registers it, one edge behind the live bus
   always @(posedge core_clk)
      bus_q <= int_dbus;
   task chk(input logic [31:0] g, e);
      comparisons++;
      if (g !== e)
      begin
         failures++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   // Request held one cycle; flags {ack,undef,flush,purge,cache} next cycle
   task xfer(input logic w, input logic [3:0] r, input logic [31:0] d,
      input logic u, input logic [4:0] e);
      {cp_req, cp_write, cp_reg, cp_wdata, cp_user_mode} = {1'b1, w, r, d, u};
      @(posedge core_clk);
      bus = bus_q; // Still the older word; this edge's update lands later
      #1 q = cp_rdata_r;
      chk({27'h0, cp_ack_r, cp_undef_r, tlb_flush_all_r, tlb_purge_r,
         unified_cache_flush_r}, {27'h0, e});
   endtask
   task print_verdict;
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // Whole run needs well under a hundred cycles
   always @(posedge core_clk)
   begin
      cyc++;
      if (cyc > 2000)
      begin
         failures++;
         print_verdict;
      end
   end
   // Requests go back to back; the user write must not disturb the word
   initial
   begin
      repeat (3) @(posedge core_clk);
      #1 sys_rst = 0;
      xfer(1, 4'h3, 32'hC000_0001, 0, 5'h10);
      xfer(1, 4'h3, 32'h5555_5555, 1, 5'h08);
      chk(domain_access_r, 32'hC000_0001);
      xfer(0, 4'h3, 32'h0, 0, 5'h10);
      chk(q, 32'h0);
      // Register 4 is skipped: software must never access it
      for (int i = 5; i < 8; i++)
      begin
         flags = {2'h2, i == 5, i == 6, i == 7};
         xfer(1, i[3:0], {8{i[3:0]}}, 0, flags);
      end
      chk(tlb_purge_addr_r, 32'h6666_6666);
      cp_req = 0;
      $display("test writes done");
      mmu.report(0, 4'hA, 4'h5, 32'h1234_5678);
      mmu.report(1, 4'h3, 4'hC, 32'hDEAD_0000);
      xfer(0, 4'h5, 32'h0, 0, 5'h10);
      chk(q, {bus[31:12], 12'h0A5});
      xfer(0, 4'h6, 32'h0, 0, 5'h10);
      chk(q, 32'h1234_5678);
      $display("test faults done");
      for (int i = 8; i < 16; i++)
      begin
         xfer(i[0], i[3:0], 32'h0, 0, 5'h08);
         chk(q, 32'h0);
      end
      xfer(1, 4'h5, 32'h0, 1, 5'h08);
      xfer(0, 4'h6, 32'h0, 1, 5'h08);
      chk(q, 32'h0);
      cp_req = 0;
      $display("test traps done");
      @(posedge core_clk);
      print_verdict;
   end
endmodule
